// file: pkg/asc_consts.vh
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH

// register indices; byte address is four times the index
`define ASC_IDX_PROG_SIZE    6'h0f
`define ASC_IDX_INTEGRITY    6'h10
`define ASC_IDX_MIN_HOUR     6'h11
`define ASC_IDX_SEC_MIN      6'h12
`define ASC_IDX_HOUR_DATE    6'h13
`define ASC_IDX_MONTH_YEAR   6'h14
`define ASC_IDX_WDAY_CTL     6'h15
`define ASC_IDX_INT_STATUS   6'h16
`define ASC_IDX_INT_MASK     6'h17

// bit positions in the integrity word
`define ASC_BIT_CFG_INIT     11
`define ASC_BIT_PROG_BAD     12
`define ASC_BIT_TABLE_INIT   13
`define ASC_BIT_CART_ADDED   14
`define ASC_BIT_LOAD_FAIL    15

// bit positions in the weekday/control word
`define ASC_BIT_ADJ          13
`define ASC_BIT_STOP         14
`define ASC_BIT_SET          15

// interrupt status / mask bits
`define ASC_INT_W            5
`define ASC_INT_CFG          0
`define ASC_INT_PROG         1
`define ASC_INT_TABLE        2
`define ASC_INT_CART         3
`define ASC_INT_LOAD         4

// resident program size codes (bcd) and word-count limits
`define ASC_CODE_4K          8'h04
`define ASC_CODE_8K          8'h08
`define ASC_CODE_12K         8'h12
`define ASC_CODE_16K         8'h16
`define ASC_LIM_3K2          16'd3277
`define ASC_LIM_7K2          16'd7373
`define ASC_LIM_11K2         16'd11469

// calendar limits (bcd)
`define ASC_BCD_ZERO         8'h00
`define ASC_BCD_ONE          8'h01
`define ASC_SEC_MAX          8'h59
`define ASC_HALF_MIN         8'h30
`define ASC_HOUR_MAX         8'h23
`define ASC_MONTH_MAX        8'h12
`define ASC_YEAR_MAX         8'h99
`define ASC_WDAY_MAX         8'h06
`define ASC_DAYS_31          8'h31
`define ASC_DAYS_30          8'h30
`define ASC_DAYS_29          8'h29
`define ASC_DAYS_28          8'h28

// clock rate and second length
`define ASC_CLK_HZ           250000000
`define ASC_TICK_S           1

`define ASC_RESET_WORD       16'h0000

`endif

// file: src/asc_aux_status.v
// Overview of operation
// - low byte word one: cassette program code
// - high byte word one: resident size code
// - config checksum fail restores defaults, bit11
// - program checksum or bad instruction, bit12
// - table checksum fail reinitialises table, bit13
// - hot cassette insertion sets bit14
// - failed power-up autoload sets bit15
// - word three: minutes low, hour high
// - word four: seconds low, minutes high
// - word five: hour low, date high
// - word six: month low, year high
// - word seven low byte: weekday 0-6
// - calendar valid only with clock cassette
// - word seven bits 13-15: adjust, stop, set
`timescale 1ns/1ps
`include "asc_consts.vh"

module asc_aux_status #(
  parameter ADDR_W      = 8,
  parameter LEN_W       = 16,
  parameter CNT_W       = 28,
  parameter TICK_CYCLES = `ASC_TICK_S * `ASC_CLK_HZ
) (
  input  wire              CORE_CLK_IN,
  input  wire              SYS_RST_IN,
  input  wire              PSEL_IN,
  input  wire              PENABLE_IN,
  input  wire              PWRITE_IN,
  input  wire [ADDR_W-1:0] PADDR_IN,
  input  wire [31:0]       PWDATA_IN,
  output reg  [31:0]       PRDATA_OUT,
  output reg               PREADY_OUT,
  output reg               PSLVERR_OUT,
  input  wire              CART_PRESENT_IN,
  input  wire [7:0]        CART_PROG_CODE_IN,
  input  wire [LEN_W-1:0]  RES_PROG_LEN_IN,
  input  wire              CLOCK_CART_IN,
  input  wire              CFG_CSUM_FAIL_IN,
  input  wire              PROG_CSUM_FAIL_IN,
  input  wire              BAD_INSTR_IN,
  input  wire              TABLE_CSUM_FAIL_IN,
  input  wire              AUTOLOAD_SW_IN,
  input  wire              LOAD_DONE_IN,
  input  wire              LOAD_OK_IN,
  output reg               CFG_RESTORE_OUT,
  output reg               TABLE_REINIT_OUT,
  output reg               IRQ_OUT
);

  // worked out at integer width, then cut to the prescaler width on purpose
  localparam [31:0]      TICK_LAST_FULL = TICK_CYCLES - 1;
  localparam [CNT_W-1:0] TICK_LAST      = TICK_LAST_FULL[CNT_W-1:0];

  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  // bcd year divisible by four: tens parity decides which ones digits qualify
  function is_leap;
    input [7:0] y;
    begin
      if (y[4]) begin
        is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end else begin
        is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end
    end
  endfunction

  function [7:0] month_days;
    input [7:0] m;
    input [7:0] y;
    begin
      case (m)
        8'h02:   month_days = is_leap(y) ? `ASC_DAYS_29 : `ASC_DAYS_28;
        8'h04:   month_days = `ASC_DAYS_30;
        8'h06:   month_days = `ASC_DAYS_30;
        8'h09:   month_days = `ASC_DAYS_30;
        8'h11:   month_days = `ASC_DAYS_30;
        default: month_days = `ASC_DAYS_31;
      endcase
    end
  endfunction

  reg  [7:0]            sec;
  reg  [7:0]            min;
  reg  [7:0]            hour;
  reg  [7:0]            date;
  reg  [7:0]            month;
  reg  [7:0]            year;
  reg  [7:0]            wday;
  reg                   ctl_adj;
  reg                   ctl_stop;
  reg                   ctl_set;
  reg  [CNT_W-1:0]      tick_cnt;
  reg                   flag_cfg;
  reg                   flag_prog;
  reg                   flag_table;
  reg                   flag_cart;
  reg                   flag_load;
  reg  [`ASC_INT_W-1:0] int_status;
  reg  [`ASC_INT_W-1:0] int_mask;
  reg                   cart_prev;
  reg                   primed;
  reg  [7:0]            res_code;

  reg  [7:0]            next_sec;
  reg  [7:0]            next_min;
  reg  [7:0]            next_hour;
  reg  [7:0]            next_date;
  reg  [7:0]            next_month;
  reg  [7:0]            next_year;
  reg  [7:0]            next_wday;
  reg                   next_adj;
  reg                   next_stop;
  reg                   next_set;
  reg                   carry_min;
  reg  [15:0]           rd_word;
  reg                   rd_hit;

  wire [5:0]  idx      = PADDR_IN[ADDR_W-1:2];
  wire        aligned  = (PADDR_IN[1:0] == 2'b00);
  wire        xfer     = PSEL_IN & PENABLE_IN & PREADY_OUT;
  wire        wr       = xfer & PWRITE_IN & aligned;
  wire [15:0] wd       = PWDATA_IN[15:0];
  // the calendar and controls only exist while a clock cassette is fitted
  wire        has_clk  = CLOCK_CART_IN;
  wire        running  = has_clk & ~ctl_stop & ~ctl_set;
  wire        tick     = running & (tick_cnt == TICK_LAST);

  wire ev_cfg   = CFG_CSUM_FAIL_IN;
  wire ev_prog  = PROG_CSUM_FAIL_IN | BAD_INSTR_IN;
  wire ev_table = TABLE_CSUM_FAIL_IN;
  wire ev_cart  = primed & CART_PRESENT_IN & ~cart_prev;
  wire ev_load  = AUTOLOAD_SW_IN & LOAD_DONE_IN & ~LOAD_OK_IN;
  wire [`ASC_INT_W-1:0] ev_vec = {ev_load, ev_cart, ev_table, ev_prog, ev_cfg};

  wire wr_mh = wr & has_clk & (idx == `ASC_IDX_MIN_HOUR);
  wire wr_sm = wr & has_clk & (idx == `ASC_IDX_SEC_MIN);
  wire wr_hd = wr & has_clk & (idx == `ASC_IDX_HOUR_DATE);
  wire wr_my = wr & has_clk & (idx == `ASC_IDX_MONTH_YEAR);
  wire wr_wc = wr & has_clk & (idx == `ASC_IDX_WDAY_CTL);

  always @* begin
    if (RES_PROG_LEN_IN < `ASC_LIM_3K2) begin
      res_code = `ASC_CODE_4K;
    end else if (RES_PROG_LEN_IN < `ASC_LIM_7K2) begin
      res_code = `ASC_CODE_8K;
    end else if (RES_PROG_LEN_IN < `ASC_LIM_11K2) begin
      res_code = `ASC_CODE_12K;
    end else begin
      res_code = `ASC_CODE_16K;
    end
  end

  // calendar: count, adjust, then software writes override
  always @* begin
    next_sec   = sec;
    next_min   = min;
    next_hour  = hour;
    next_date  = date;
    next_month = month;
    next_year  = year;
    next_wday  = wday;
    next_adj   = ctl_adj;
    next_stop  = ctl_stop;
    next_set   = ctl_set;
    carry_min  = 1'b0;
    if (ctl_adj) begin
      next_sec  = `ASC_BCD_ZERO;
      carry_min = (sec >= `ASC_HALF_MIN);
      next_adj  = 1'b0;
    end else if (tick) begin
      if (sec == `ASC_SEC_MAX) begin
        next_sec  = `ASC_BCD_ZERO;
        carry_min = 1'b1;
      end else begin
        next_sec = bcd_inc(sec);
      end
    end
    if (carry_min) begin
      if (min == `ASC_SEC_MAX) begin
        next_min = `ASC_BCD_ZERO;
        if (hour == `ASC_HOUR_MAX) begin
          next_hour = `ASC_BCD_ZERO;
          next_wday = (wday == `ASC_WDAY_MAX) ? `ASC_BCD_ZERO : bcd_inc(wday);
          if (date == month_days(month, year)) begin
            next_date = `ASC_BCD_ONE;
            if (month == `ASC_MONTH_MAX) begin
              next_month = `ASC_BCD_ONE;
              next_year  = (year == `ASC_YEAR_MAX) ? `ASC_BCD_ZERO : bcd_inc(year);
            end else begin
              next_month = bcd_inc(month);
            end
          end else begin
            next_date = bcd_inc(date);
          end
        end else begin
          next_hour = bcd_inc(hour);
        end
      end else begin
        next_min = bcd_inc(min);
      end
    end
    if (wr_mh) begin
      next_min  = wd[7:0];
      next_hour = wd[15:8];
    end
    if (wr_sm) begin
      next_sec = wd[7:0];
      next_min = wd[15:8];
    end
    if (wr_hd) begin
      next_hour = wd[7:0];
      next_date = wd[15:8];
    end
    if (wr_my) begin
      next_month = wd[7:0];
      next_year  = wd[15:8];
    end
    if (wr_wc) begin
      next_wday = wd[7:0];
      next_adj  = wd[`ASC_BIT_ADJ];
      next_stop = wd[`ASC_BIT_STOP];
      next_set  = wd[`ASC_BIT_SET];
    end
    if (!has_clk) begin
      next_adj  = 1'b0;
      next_stop = 1'b0;
      next_set  = 1'b0;
    end
  end

  always @* begin
    rd_word = `ASC_RESET_WORD;
    rd_hit  = aligned;
    case (idx)
      `ASC_IDX_PROG_SIZE: begin
        rd_word = {res_code, CART_PRESENT_IN ? CART_PROG_CODE_IN : `ASC_BCD_ZERO};
      end
      `ASC_IDX_INTEGRITY: begin
        rd_word[`ASC_BIT_CFG_INIT]   = flag_cfg;
        rd_word[`ASC_BIT_PROG_BAD]   = flag_prog;
        rd_word[`ASC_BIT_TABLE_INIT] = flag_table;
        rd_word[`ASC_BIT_CART_ADDED] = flag_cart;
        rd_word[`ASC_BIT_LOAD_FAIL]  = flag_load;
      end
      `ASC_IDX_MIN_HOUR:   rd_word = has_clk ? {hour, min} : `ASC_RESET_WORD;
      `ASC_IDX_SEC_MIN:    rd_word = has_clk ? {min, sec} : `ASC_RESET_WORD;
      `ASC_IDX_HOUR_DATE:  rd_word = has_clk ? {date, hour} : `ASC_RESET_WORD;
      `ASC_IDX_MONTH_YEAR: rd_word = has_clk ? {year, month} : `ASC_RESET_WORD;
      `ASC_IDX_WDAY_CTL: begin
        if (has_clk) begin
          rd_word[7:0]           = wday;
          rd_word[`ASC_BIT_ADJ]  = ctl_adj;
          rd_word[`ASC_BIT_STOP] = ctl_stop;
          rd_word[`ASC_BIT_SET]  = ctl_set;
        end
      end
      `ASC_IDX_INT_STATUS: rd_word[`ASC_INT_W-1:0] = int_status;
      `ASC_IDX_INT_MASK:   rd_word[`ASC_INT_W-1:0] = int_mask;
      default:             rd_hit = 1'b0;
    endcase
  end

  // one wait state: pready rises in the second access cycle, data registered with it
  always @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      PREADY_OUT  <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT  <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
      PSLVERR_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~rd_hit;
      if (PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~PWRITE_IN & rd_hit) begin
        PRDATA_OUT <= {16'h0000, rd_word};
      end else begin
        PRDATA_OUT <= 32'h0000_0000;
      end
    end
  end

  always @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sec      <= `ASC_BCD_ZERO;
      min      <= `ASC_BCD_ZERO;
      hour     <= `ASC_BCD_ZERO;
      date     <= `ASC_BCD_ONE;
      month    <= `ASC_BCD_ONE;
      year     <= `ASC_BCD_ZERO;
      wday     <= `ASC_BCD_ZERO;
      ctl_adj  <= 1'b0;
      ctl_stop <= 1'b0;
      ctl_set  <= 1'b0;
      tick_cnt <= {CNT_W{1'b0}};
    end else begin
      sec      <= next_sec;
      min      <= next_min;
      hour     <= next_hour;
      date     <= next_date;
      month    <= next_month;
      year     <= next_year;
      wday     <= next_wday;
      ctl_adj  <= next_adj;
      ctl_stop <= next_stop;
      ctl_set  <= next_set;
      // held at zero while set, so releasing set starts a full fresh second
      if (!running || tick || wr_sm) begin
        tick_cnt <= {CNT_W{1'b0}};
      end else begin
        tick_cnt <= tick_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // flags are sticky until reset; the word is read-only to software
  always @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      flag_cfg         <= 1'b0;
      flag_prog        <= 1'b0;
      flag_table       <= 1'b0;
      flag_cart        <= 1'b0;
      flag_load        <= 1'b0;
      cart_prev        <= 1'b0;
      primed           <= 1'b0;
      CFG_RESTORE_OUT  <= 1'b0;
      TABLE_REINIT_OUT <= 1'b0;
    end else begin
      // first edge after release only samples presence: a cassette fitted at power-up is no insertion
      primed           <= 1'b1;
      cart_prev        <= CART_PRESENT_IN;
      CFG_RESTORE_OUT  <= ev_cfg;
      TABLE_REINIT_OUT <= ev_table;
      flag_cfg         <= flag_cfg | ev_cfg;
      flag_prog        <= flag_prog | ev_prog;
      flag_table       <= flag_table | ev_table;
      flag_cart        <= flag_cart | ev_cart;
      flag_load        <= flag_load | ev_load;
    end
  end

  always @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      int_status <= {`ASC_INT_W{1'b0}};
      int_mask   <= {`ASC_INT_W{1'b0}};
      IRQ_OUT    <= 1'b0;
    end else begin
      if (wr && idx == `ASC_IDX_INT_MASK) begin
        int_mask <= wd[`ASC_INT_W-1:0];
      end
      // a new event beats a write-one-to-clear in the same cycle
      if (wr && idx == `ASC_IDX_INT_STATUS) begin
        int_status <= (int_status & ~wd[`ASC_INT_W-1:0]) | ev_vec;
      end else begin
        int_status <= int_status | ev_vec;
      end
      IRQ_OUT <= |(int_status & int_mask);
    end
  end

endmodule

// file: bench/asc_aux_status_checker.sv
`timescale 1ns/1ps
module asc_aux_status_checker #(
  parameter ADDR_W = 8
) (
  input wire              CORE_CLK_IN,
  input wire              SYS_RST_IN,
  input wire              PWRITE_IN,
  input wire [ADDR_W-1:0] PADDR_IN,
  input wire [31:0]       PRDATA_OUT,
  input wire              PREADY_OUT,
  input wire              PSLVERR_OUT,
  input wire              CART_PRESENT_IN,
  input wire [7:0]        CART_PROG_CODE_IN,
  input wire              CLOCK_CART_IN,
  input wire              CFG_CSUM_FAIL_IN,
  input wire              TABLE_CSUM_FAIL_IN,
  input wire              CFG_RESTORE_OUT,
  input wire              TABLE_REINIT_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  wire rd = PREADY_OUT && !PWRITE_IN && !PSLVERR_OUT;
  property p_size;
    rd && PADDR_IN == 8'h3c |-> PRDATA_OUT[15:8] inside {8'h04, 8'h08, 8'h12, 8'h16}
      && PRDATA_OUT[7:0] == (CART_PRESENT_IN ? CART_PROG_CODE_IN : 8'h00);
  endproperty
  a_size: assert property (p_size) else $error("size code word wrong");
  property p_cfg;
    CFG_CSUM_FAIL_IN |=> CFG_RESTORE_OUT;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config restore missing");
  property p_tbl;
    TABLE_REINIT_OUT == $past(TABLE_CSUM_FAIL_IN);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table reinit mismatch");
  property p_flag_unused;
    rd && PADDR_IN == 8'h40 |-> PRDATA_OUT[10:0] == 11'h0;
  endproperty
  a_flag_unused: assert property (p_flag_unused) else $error("flag word low bits set");
  property p_wday;
    rd && PADDR_IN == 8'h54 |-> PRDATA_OUT[12:8] == 5'h0 && PRDATA_OUT[7:0] <= 8'h06;
  endproperty
  a_wday: assert property (p_wday) else $error("weekday word wrong");
  property p_nocart;
    rd && !CLOCK_CART_IN && PADDR_IN >= 8'h44 && PADDR_IN <= 8'h54 |-> PRDATA_OUT == 32'h0;
  endproperty
  a_nocart: assert property (p_nocart) else $error("time shown without clock");
  property p_upper;
    PREADY_OUT |-> PRDATA_OUT[31:16] == 16'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_err;
    PREADY_OUT && PSLVERR_OUT |-> PRDATA_OUT == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error read not zero");
  c_err: cover property (PREADY_OUT && PSLVERR_OUT);
  c_cfg: cover property (CFG_RESTORE_OUT);
  c_wday: cover property (rd && PADDR_IN == 8'h54);
endmodule

bind asc_aux_status asc_aux_status_checker #(.ADDR_W(ADDR_W)) i_asc_aux_status_checker (
  .CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .PWRITE_IN(PWRITE_IN),
  .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .CART_PRESENT_IN(CART_PRESENT_IN),
  .CART_PROG_CODE_IN(CART_PROG_CODE_IN), .CLOCK_CART_IN(CLOCK_CART_IN),
  .CFG_CSUM_FAIL_IN(CFG_CSUM_FAIL_IN), .TABLE_CSUM_FAIL_IN(TABLE_CSUM_FAIL_IN),
  .CFG_RESTORE_OUT(CFG_RESTORE_OUT), .TABLE_REINIT_OUT(TABLE_REINIT_OUT));

// file: bench/tb.sv
`timescale 1ns/1ps
`include "asc_consts.vh"
module tb;
  localparam TICK = 25;
  reg          clk, rst, psel, pen, pwr, cart, clkcart, cfg, prog, bad, tbl, asw, ldone, lok;
  reg  [7:0]   paddr, ccode, code;
  reg  [31:0]  pwdata;
  reg  [15:0]  plen, n, flags;
  wire [31:0]  prdata;
  wire         prdy, perr, crst, trei, irq;
  integer      n_mismatch, n_checks, cyc, seed, i;
  reg  [32:0]  exp_q[$];
  reg  [31:0]  msk_q[$];

  asc_aux_status #(.TICK_CYCLES(TICK)) i_asc_aux_status (
    .CORE_CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .CART_PRESENT_IN(cart),
    .CART_PROG_CODE_IN(ccode), .RES_PROG_LEN_IN(plen), .CLOCK_CART_IN(clkcart),
    .CFG_CSUM_FAIL_IN(cfg), .PROG_CSUM_FAIL_IN(prog), .BAD_INSTR_IN(bad),
    .TABLE_CSUM_FAIL_IN(tbl), .AUTOLOAD_SW_IN(asw), .LOAD_DONE_IN(ldone),
    .LOAD_OK_IN(lok), .CFG_RESTORE_OUT(crst), .TABLE_REINIT_OUT(trei), .IRQ_OUT(irq));

  always #2 clk = ~clk;

  task chk(input [32:0] got, input [32:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task chk_irq(input e);
    begin
      chk({32'h0, irq}, {32'h0, e});
    end
  endtask

  task close_out;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // the expectation is queued first; the monitor pops it at the ready edge
  task apb(input w, input [7:0] a, input [15:0] d, input [31:0] m, input [32:0] e);
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= {16'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (prdy !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, input [31:0] m, input [31:0] e);
    apb(1'b0, a, 16'h0, m, {1'b0, e & m});
  endtask

  task wr(input [7:0] a, input [15:0] d);
    apb(1'b1, a, d, 32'hffffffff, 33'h0);
  endtask

  task pulse_clear;
    begin
      @(posedge clk);
      {cfg, prog, bad, tbl, ldone} <= 5'h0;
    end
  endtask

  always @(posedge clk) begin
    if (prdy === 1'b1 && exp_q.size() > 0)
      chk({perr, prdata & msk_q.pop_front()}, exp_q.pop_front());
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      close_out;
    end
  end

  initial begin
    clk = 0; rst = 1; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0; cart = 0;
    clkcart = 0; ccode = 8'h07; plen = 0; cfg = 0; prog = 0; bad = 0; tbl = 0;
    asw = 1; ldone = 0; lok = 0; n_mismatch = 0; n_checks = 0; cyc = 0;
    seed = 32'hb5cb; flags = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h3c, 32'hffff, 32'h0400);
    wr(8'h48, 16'h1234);
    rd(8'h48, 32'hffffffff, 32'h0);
    wr(8'h3c, 16'hffff);
    rd(8'h3c, 32'hffff, 32'h0400);
    apb(1'b0, 8'h00, 16'h0, 32'hffffffff, 33'h100000000);
    apb(1'b1, 8'h60, 16'hffff, 32'hffffffff, 33'h100000000);
    apb(1'b0, 8'h41, 16'h0, 32'hffffffff, 33'h100000000);
    $display("done access");
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge clk);
      case (i)
        0: begin cart <= 1'b1; clkcart <= 1'b1; flags = 16'h4000; end
        1: begin cfg <= 1'b1; flags = flags | 16'h0800; end
        2: begin bad <= 1'b1; flags = flags | 16'h1000; end
        3: begin tbl <= 1'b1; flags = flags | 16'h2000; end
        default: begin ldone <= 1'b1; flags = flags | 16'h8000; end
      endcase
      pulse_clear;
      rd(8'h40, 32'hffff, {16'h0, flags});
    end
    rd(8'h58, 32'hffff, 32'h001f);
    chk_irq(1'b0);
    wr(8'h5c, 16'h0004);
    rd(8'h5c, 32'hffff, 32'h0004);
    repeat (3) @(posedge clk);
    chk_irq(1'b1);
    wr(8'h58, 16'h0004);
    repeat (3) @(posedge clk);
    chk_irq(1'b0);
    rd(8'h58, 32'hffff, 32'h001b);
    $display("done events");
    for (i = 0; i < 8; i = i + 1) begin
      case (i)
        0: n = 16'd3276;
        1: n = 16'd7373;
        2: n = 16'd11468;
        3: n = 16'd11469;
        default: n = $random(seed);
      endcase
      code = $random(seed);
      @(posedge clk);
      plen <= n;
      ccode <= code;
      rd(8'h3c, 32'hffff, {16'h0, (n < `ASC_LIM_3K2) ? `ASC_CODE_4K : (n < `ASC_LIM_7K2) ?
        `ASC_CODE_8K : (n < `ASC_LIM_11K2) ? `ASC_CODE_12K : `ASC_CODE_16K, code});
    end
    $display("done size");
    rd(8'h4c, 32'hffff, 32'h0100);
    rd(8'h50, 32'hffff, 32'h0001);
    wr(8'h54, 16'h8006);
    wr(8'h48, 16'h5945);
    wr(8'h44, 16'h2359);
    wr(8'h4c, 16'h2823);
    wr(8'h50, 16'h9902);
    rd(8'h48, 32'hffff, 32'h5945);
    rd(8'h44, 32'hffff, 32'h2359);
    rd(8'h4c, 32'hffff, 32'h2823);
    rd(8'h50, 32'hffff, 32'h9902);
    rd(8'h54, 32'hffff, 32'h8006);
    // half-minute adjust at 23:59:45 on the last day of a non-leap february carries into march
    wr(8'h54, 16'h2006);
    rd(8'h44, 32'hffff, 32'h0000);
    rd(8'h4c, 32'hffff, 32'h0100);
    rd(8'h50, 32'hffff, 32'h9903);
    rd(8'h54, 32'hffff, 32'h0000);
    wr(8'h48, 16'h1259);
    rd(8'h48, 32'hffff, 32'h1259);
    repeat (30) @(posedge clk);
    rd(8'h48, 32'hffff, 32'h1300);
    wr(8'h54, 16'h4000);
    wr(8'h48, 16'h3030);
    repeat (60) @(posedge clk);
    rd(8'h48, 32'hffff, 32'h3030);
    rd(8'h44, 32'h00ff, 32'h0030);
    // below half a minute the adjust only clears the seconds, even while stopped
    wr(8'h48, 16'h3029);
    wr(8'h54, 16'h6000);
    rd(8'h48, 32'hffff, 32'h3000);
    rd(8'h54, 32'hffff, 32'h4000);
    $display("done clock");
    @(posedge clk);
    rst <= 1'b1;
    asw <= 1'b0;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    prog <= 1'b1;
    ldone <= 1'b1;
    pulse_clear;
    rd(8'h40, 32'hffff, 32'h1000);
    $display("done reset");
    // let the monitor take the last read before the queue is judged
    @(posedge clk);
    if (exp_q.size() != 0)
      n_mismatch = n_mismatch + 1;
    close_out;
  end
endmodule
